/* File: core/jesd_link_align.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Octet buffer between the transport feed and the link framer.
module jesd_octet_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Filling side.
    input wire logic wr_valid,
    input wire logic [W-1:0] wr_data,
    output logic wr_ready,
    // Draining side.
    output logic rd_valid,
    output logic [W-1:0] rd_data,
    input wire logic rd_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D]; // Storage; D must be a power of two.
    logic [AW-1:0] wp_r, wp_nxt;
    logic [AW-1:0] rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Honest flags straight from the fill count.
    // The count is one bit wider than the pointers, so compare at that width.
    assign wr_ready = (cnt_r != (AW + 1)'(D));
    assign rd_valid = (cnt_r != '0);
    assign rd_data = mem[rp_r];
    assign push = wr_valid && wr_ready;
    assign pop = rd_valid && rd_ready;

    // Pointer and count update.
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Registers; memory contents need no reset.
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp_r] <= wr_data;
        end
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Alignment sequence starts at LMFC after sync rise
// - Four multiframes, each /R/ first, /A/ last
// - Second multiframe carries link configuration
// - Unscrambled repeated last octet sent as /F/
// - Unscrambled repeat at multiframe end sent /A/
// - Scrambled frame end 0xFC sent as /F/
// - Scrambled multiframe end 0x7C sent as /A/
// - Eight octets per block after sync header
// - 32 blocks per multiblock, E per extended
// - SYSREF resets extended multiblock phase
// - Sync header 01 is one, 10 zero
// - Header bits form 32-bit stream per multiblock
// - Stream ends 00001, unique in CRC mode
// - Bit 22 set only in last multiblock
// - Only CRC-12 and FEC stream formats
// - Comma stream while sync request is low
// - Scrambling always on in 64B/66B mode
module jesd_link_align
    import jesd_align_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Static configuration, sampled only while in reset.
    input wire logic cfg_mode64,
    input wire logic cfg_scr,
    input wire logic cfg_fec,
    input wire logic [7:0] cfg_f_m1,
    input wire logic [7:0] cfg_k_m1,
    input wire logic [7:0] cfg_e_m1,
    // Link control from the receiver and the clock tree.
    input wire logic sync_n,
    input wire logic sysref,
    // Octet feed, already scrambled upstream where scrambling is on.
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    // Parity word for the next sync header stream.
    input wire logic [25:0] shs_parity,
    // 8B/10B octet output.
    output logic [7:0] tx_octet,
    output logic tx_k,
    // 64B/66B block output; bit index is line position.
    output logic [BLK_W-1:0] tx_blk,
    output logic tx_blk_valid,
    // Status.
    output logic scr_active,
    output logic underflow
);

    ////////////////////////////////////////////////////////////////////////
    // State and wiring.
    logic mode64_r, mode64_nxt; // Captured configuration.
    logic scr_r, scr_nxt;
    logic fec_r, fec_nxt;
    logic [7:0] f_m1_r, f_m1_nxt;
    logic [7:0] k_m1_r, k_m1_nxt;
    logic [7:0] e_m1_r, e_m1_nxt;
    link_st_e st_r, st_nxt; // Link state.
    logic sync_d_r, sref_d_r; // Previous input levels for edges.
    logic [7:0] fo_r, fo_nxt; // Octet within frame.
    logic [7:0] fr_r, fr_nxt; // Frame within multiframe.
    logic [9:0] mo_r, mo_nxt; // Octet within multiframe.
    logic [1:0] ilas_r, ilas_nxt; // Alignment multiframe number.
    logic [2:0] byte_r, byte_nxt; // Octet within block.
    logic [4:0] blk_r, blk_nxt; // Block within multiblock.
    logic [7:0] emb_r, emb_nxt; // Multiblock within extended one.
    logic [7:0] prev_r, prev_nxt; // Last octet of the previous frame.
    logic [55:0] acc_r, acc_nxt; // First seven octets of a block.
    logic [31:0] shs_r, shs_nxt; // Sync header stream in flight.
    logic [7:0] oct_r, oct_nxt;
    logic k_r, k_nxt;
    logic [BLK_W-1:0] blk_out_r, blk_out_nxt;
    logic bv_r, bv_nxt;
    logic unf_r, unf_nxt;
    logic fe, me, be, mbe, eme, sref_rise, drain, f_v;
    logic [7:0] f_d, d;

    assign fe = (fo_r == f_m1_r);
    assign me = fe && (fr_r == k_m1_r);
    assign be = (byte_r == LAST_BYTE);
    assign mbe = be && (blk_r == LAST_BLK);
    assign eme = mbe && (emb_r == e_m1_r);
    assign sref_rise = sysref && !sref_d_r;
    // The buffer drains only while user data flows, so it fills otherwise.
    assign drain = (st_r == ST_DATA);
    assign d = f_v ? f_d : IDLE_OCT;

    jesd_octet_fifo #(
        .W(8),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .wr_valid(in_valid),
        .wr_data(in_data),
        .wr_ready(in_ready),
        .rd_valid(f_v),
        .rd_data(f_d),
        .rd_ready(drain)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for counters, link state and outputs.
    always_comb begin
        // Configuration only follows the ports during reset.
        mode64_nxt = rst ? cfg_mode64 : mode64_r;
        scr_nxt = rst ? cfg_scr : scr_r;
        fec_nxt = rst ? cfg_fec : fec_r;
        f_m1_nxt = rst ? cfg_f_m1 : f_m1_r;
        k_m1_nxt = rst ? cfg_k_m1 : k_m1_r;
        e_m1_nxt = rst ? cfg_e_m1 : e_m1_r;
        // Multiframe and extended multiblock position counters.
        fo_nxt = fe ? '0 : fo_r + 1'b1;
        fr_nxt = me ? '0 : (fe ? fr_r + 1'b1 : fr_r);
        mo_nxt = me ? '0 : mo_r + 1'b1;
        byte_nxt = byte_r + 1'b1;
        blk_nxt = be ? blk_r + 1'b1 : blk_r;
        emb_nxt = eme ? '0 : (mbe ? emb_r + 1'b1 : emb_r);
        if (sref_rise) begin
            // A SYSREF edge forces a deterministic phase.
            fo_nxt = '0;
            fr_nxt = '0;
            mo_nxt = '0;
            byte_nxt = '0;
            blk_nxt = '0;
            emb_nxt = '0;
        end
        // The stream is latched just before each multiblock begins.
        shs_nxt = shs_r;
        if (byte_nxt == '0 && blk_nxt == '0) begin
            shs_nxt = build_shs(shs_parity, fec_r,
                                emb_nxt == e_m1_r);
        end
        st_nxt = st_r;
        ilas_nxt = ilas_r;
        prev_nxt = prev_r;
        acc_nxt = acc_r;
        oct_nxt = IDLE_OCT;
        k_nxt = 1'b0;
        blk_out_nxt = blk_out_r;
        bv_nxt = 1'b0;
        unf_nxt = drain && !f_v;
        if (mode64_r) begin
            // 64B/66B: wait for the extended multiblock edge, then stream.
            if (st_r != ST_DATA && byte_nxt == '0 && blk_nxt == '0 &&
                emb_nxt == '0) begin
                st_nxt = ST_DATA;
            end
            if (st_r == ST_DATA) begin
                // The eighth octet goes straight into the block, not here.
                if (!be) begin
                    acc_nxt[8*byte_r +: 8] = d;
                end
                if (be) begin
                    for (int j = 0; j < 7; j++) begin
                        blk_out_nxt[2+8*j +: 8] = acc_r[8*j +: 8];
                    end
                    blk_out_nxt[58 +: 8] = d;
                    blk_out_nxt[1:0] = shs_r[blk_r] ? SH_ONE
                                                    : SH_ZERO;
                    bv_nxt = 1'b1;
                end
            end
        end else begin
            unique case (st_r)
                ST_CGS: begin
                    oct_nxt = K_COMMA;
                    k_nxt = 1'b1;
                    if (sync_n && !sync_d_r) begin
                        st_nxt = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    oct_nxt = K_COMMA;
                    k_nxt = 1'b1;
                    if (mo_nxt == '0) begin
                        st_nxt = ST_ILAS;
                    end
                    ilas_nxt = '0;
                end
                ST_ILAS: begin
                    // Never scrambled: octets go out as built here.
                    oct_nxt = mo_r[7:0];
                    if (mo_r == '0) begin
                        oct_nxt = K_R;
                        k_nxt = 1'b1;
                    end else if (me) begin
                        oct_nxt = K_A;
                        k_nxt = 1'b1;
                    end else if (ilas_r == ILAS_CFG_MF) begin
                        if (mo_r == ILAS_Q_POS) begin
                            oct_nxt = K_Q;
                            k_nxt = 1'b1;
                        end else if (mo_r == ILAS_CFG_F) begin
                            oct_nxt = f_m1_r;
                        end else if (mo_r == ILAS_CFG_K) begin
                            oct_nxt = k_m1_r;
                        end else if (mo_r == ILAS_CFG_M) begin
                            oct_nxt = {6'h00, fec_r, scr_r};
                        end
                    end
                    if (me) begin
                        ilas_nxt = ilas_r + 1'b1;
                        if (ilas_r == ILAS_LAST_MF) begin
                            st_nxt = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    oct_nxt = d;
                    if (fe) begin
                        prev_nxt = d;
                        if (scr_r) begin
                            if (me && d == SCR_A_OCT) begin
                                oct_nxt = K_A;
                                k_nxt = 1'b1;
                            end else if (d == SCR_F_OCT) begin
                                oct_nxt = K_F;
                                k_nxt = 1'b1;
                            end
                        end else if (d == prev_r) begin
                            oct_nxt = me ? K_A : K_F;
                            k_nxt = 1'b1;
                        end
                    end
                end
            endcase
            // A low request always falls back to commas.
            if (!sync_n) begin
                st_nxt = ST_CGS;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers; reset puts the link in its start state per mode.
    always_ff @(posedge sys_clk) begin
        mode64_r <= mode64_nxt;
        scr_r <= scr_nxt;
        fec_r <= fec_nxt;
        f_m1_r <= f_m1_nxt;
        k_m1_r <= k_m1_nxt;
        e_m1_r <= e_m1_nxt;
        if (rst) begin
            st_r <= cfg_mode64 ? ST_WAIT : ST_CGS;
            sync_d_r <= 1'b0;
            sref_d_r <= 1'b0;
            {fo_r, fr_r, mo_r, ilas_r} <= '0;
            {byte_r, blk_r, emb_r} <= '0;
            {prev_r, acc_r, shs_r} <= '0;
            {oct_r, k_r, blk_out_r, bv_r, unf_r} <= '0;
        end else begin
            st_r <= st_nxt;
            sync_d_r <= sync_n;
            sref_d_r <= sysref;
            {fo_r, fr_r, mo_r, ilas_r} <= {fo_nxt, fr_nxt, mo_nxt, ilas_nxt};
            {byte_r, blk_r, emb_r} <= {byte_nxt, blk_nxt, emb_nxt};
            {prev_r, acc_r, shs_r} <= {prev_nxt, acc_nxt, shs_nxt};
            {oct_r, k_r, blk_out_r} <= {oct_nxt, k_nxt, blk_out_nxt};
            {bv_r, unf_r} <= {bv_nxt, unf_nxt};
        end
    end

    assign tx_octet = oct_r;
    assign tx_k = k_r;
    assign tx_blk = blk_out_r;
    assign tx_blk_valid = bv_r;
    assign underflow = unf_r;
    assign scr_active = mode64_r || scr_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the framer's outputs and its internal counters and state.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ilas_lmfc: assert property (st_r == ST_WAIT && st_nxt == ST_ILAS
        && !mode64_r |=> mo_r == '0) else $error("late start");
    a_ilas_first: assert property (st_r == ST_ILAS && mo_r == '0
        |=> tx_k && tx_octet == K_R) else $error("no /R/");
    a_ilas_last: assert property (st_r == ST_ILAS && me && sync_n
        |=> tx_k && tx_octet == K_A) else $error("no /A/");
    a_ilas_len: assert property (st_r == ST_ILAS && me && sync_n &&
        ilas_r == ILAS_LAST_MF |=> st_r == ST_DATA)
        else $error("ILAS length");
    a_ilas_cfg: assert property (st_r == ST_ILAS && ilas_r == ILAS_CFG_MF
        && mo_r == ILAS_Q_POS && !me |=> tx_k && tx_octet == K_Q)
        else $error("no config marker");
    a_unscr_f: assert property (!mode64_r && !scr_r && st_r == ST_DATA &&
        fe && !me && d == prev_r |=> tx_k && tx_octet == K_F)
        else $error("no /F/");
    a_unscr_a: assert property (!mode64_r && !scr_r && st_r == ST_DATA &&
        me && d == prev_r |=> tx_k && tx_octet == K_A)
        else $error("no /A/ repeat");
    a_scr_f: assert property (!mode64_r && scr_r && st_r == ST_DATA && fe
        && !me && d == SCR_F_OCT |=> tx_k && tx_octet == K_F)
        else $error("no scrambled /F/");
    a_scr_a: assert property (!mode64_r && scr_r && st_r == ST_DATA && me
        && d == SCR_A_OCT |=> tx_k && tx_octet == K_A)
        else $error("no scrambled /A/");
    a_cgs_comma: assert property (!mode64_r && !sync_n ##1 !rst
        |=> tx_k && tx_octet == K_COMMA) else $error("no comma");
    a_sysref_phase: assert property (sysref && !sref_d_r
        |=> mo_r == '0 && byte_r == '0 && emb_r == '0)
        else $error("phase not reset");
    a_emb_wrap: assert property (eme && !sysref
        |=> blk_r == '0 && emb_r == '0) else $error("bad wrap");
    a_sh_pair: assert property (tx_blk_valid
        |-> tx_blk[0] != tx_blk[1]) else $error("bad header");
    a_shs_tail: assert property (mode64_r && st_r == ST_DATA
        |-> shs_r[31:27] == SH_PILOT) else $error("no pilot");
    a_eoemb_bit: assert property (mode64_r && st_r == ST_DATA
        |-> shs_r[SH_EOEMB] == (emb_r == e_m1_r))
        else $error("bad EoEMB");
    a_cfg_hold: assert property (1'b1 |=> $stable(f_m1_r) &&
        $stable(mode64_r) && $stable(e_m1_r))
        else $error("config moved");

    c_ilas_run: cover property (st_r == ST_ILAS ##1 st_r == ST_DATA);
    c_frame_f: cover property (tx_k && tx_octet == K_F);
    c_block_out: cover property (tx_blk_valid && blk_r == '0);
    c_underflow: cover property (underflow);
endmodule

/* File: core/jesd_align_pkg.sv */
package jesd_align_pkg;

    // Control characters, as the octet handed to the 8B/10B encoder.
    localparam logic [7:0] K_COMMA = 8'hBC;
    localparam logic [7:0] K_R = 8'h1C;
    localparam logic [7:0] K_A = 8'h7C;
    localparam logic [7:0] K_Q = 8'h9C;
    localparam logic [7:0] K_F = 8'hFC;

    // Scrambled octets that travel as /F/ and /A/ at frame ends.
    localparam logic [7:0] SCR_F_OCT = 8'hFC;
    localparam logic [7:0] SCR_A_OCT = 8'h7C;

    // Octet sent when the data buffer runs dry.
    localparam logic [7:0] IDLE_OCT = 8'h00;

    // Alignment sequence layout: multiframe numbers, then octet index inside a multiframe.
    localparam logic [1:0] ILAS_LAST_MF = 2'h3;
    localparam logic [1:0] ILAS_CFG_MF = 2'h1;
    localparam logic [9:0] ILAS_Q_POS = 10'h001;
    localparam logic [9:0] ILAS_CFG_F = 10'h002;
    localparam logic [9:0] ILAS_CFG_K = 10'h003;
    localparam logic [9:0] ILAS_CFG_M = 10'h004;

    // Block and multiblock geometry.
    localparam logic [2:0] LAST_BYTE = 3'h7;
    localparam logic [4:0] LAST_BLK = 5'h1F;
    localparam int BLK_W = 66;
    localparam int SH_EOEMB = 22;
    localparam logic [1:0] SH_ONE = 2'h2;
    localparam logic [1:0] SH_ZERO = 2'h1;
    localparam logic [4:0] SH_PILOT = 5'h10;

    // Link states, Gray coded along comma, wait, alignment, data.
    typedef enum logic [1:0] {
        ST_CGS = 2'h0,
        ST_WAIT = 2'h1,
        ST_ILAS = 2'h3,
        ST_DATA = 2'h2
    } link_st_e;

    // Builds one 32-bit sync header stream; bit i rides on block i.
    function automatic logic [31:0] build_shs(input logic [25:0] par,
                                              input logic fec,
                                              input logic eoemb);
        logic [31:0] s;
        s = 32'h0000_0000;
        if (fec) begin
            // Parity goes out most significant bit first.
            for (int i = 0; i < 22; i++) begin
                s[i] = par[25 - i];
            end
            for (int i = 0; i < 4; i++) begin
                s[23 + i] = par[3 - i];
            end
        end else begin
            // Fixed ones keep the end pattern unique in CRC mode.
            s = 32'h00A8_8888;
            // Every third parity bit is followed by a fixed one.
            for (int i = 0; i < 12; i++) begin
                s[i + i / 3] = par[11 - i];
            end
        end
        s[SH_EOEMB] = eoemb;
        s[31:27] = SH_PILOT;
        return s;
    endfunction

endpackage

/* File: dv/jesd_rx_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Receiver stand-in: holds the sync request low until it has seen a run of
// commas, and again whenever the bench asks it to realign the link.
module jesd_rx_model
    import jesd_align_pkg::*;
#(
    parameter int COMMAS = 4
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Octets from the transmitter.
    input wire logic [7:0] tx_octet,
    input wire logic tx_k,
    // Realignment request from the bench.
    input wire logic realign,
    // Sync request, active low.
    output logic sync_n
);
    // Consecutive commas seen since the last restart.
    int seen_r;

    // A realign request restarts the search; a broken run starts it again.
    always_ff @(posedge sys_clk) begin
        if (rst || realign) begin
            seen_r <= 0;
        end else if (tx_k && tx_octet == K_COMMA) begin
            seen_r <= (seen_r < COMMAS) ? seen_r + 1 : seen_r;
        end else if (seen_r < COMMAS) begin
            seen_r <= 0;
        end
    end

    // Released only after a full run, so a stray comma never counts.
    assign sync_n = (seen_r >= COMMAS);
endmodule

/* File: dv/jesd_link_align_bench.sv */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the link framer, with a receiver model.
module jesd_link_align_bench
    import jesd_align_pkg::*;
;
    // Stimulus and observed ports.
    logic sys_clk, rst, cfg_mode64, cfg_scr, cfg_fec, sync_n, sysref;
    logic [7:0] cfg_f_m1, cfg_k_m1, cfg_e_m1, in_data, tx_octet;
    logic in_valid, in_ready, tx_k, tx_blk_valid, scr_active, underflow;
    logic realign;
    logic [25:0] shs_parity;
    logic [BLK_W-1:0] tx_blk;
    // Tallies for the verdict.
    int miscompares, tests_run;
    // Octets fed in and what the line should carry for them.
    logic [7:0] din [32];
    logic [7:0] eo [32];
    logic ek [32];

    jesd_link_align #(.FIFO_DEPTH(32)) jesd_link_align_inst (
        .sys_clk(sys_clk), .rst(rst), .cfg_mode64(cfg_mode64),
        .cfg_scr(cfg_scr), .cfg_fec(cfg_fec), .cfg_f_m1(cfg_f_m1),
        .cfg_k_m1(cfg_k_m1), .cfg_e_m1(cfg_e_m1), .sync_n(sync_n),
        .sysref(sysref), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .shs_parity(shs_parity),
        .tx_octet(tx_octet), .tx_k(tx_k), .tx_blk(tx_blk),
        .tx_blk_valid(tx_blk_valid), .scr_active(scr_active),
        .underflow(underflow));

    jesd_rx_model #(.COMMAS(4)) jesd_rx_model_inst (
        .sys_clk(sys_clk), .rst(rst), .tx_octet(tx_octet), .tx_k(tx_k),
        .realign(realign), .sync_n(sync_n));

    // A 40 ns clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers.
    // Samples land just after the edge, once its updates have settled.
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask

    // Four-state compare, so an unknown never passes.
    task automatic chk(input logic [65:0] got, input logic [65:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h",
                     $time, got, exp);
        end
    endtask

    // The single exit of the run.
    task automatic conclude;
        if (miscompares == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // A bounded wait that ran out.
    task automatic expire;
        miscompares++;
        conclude();
    endtask

    // Reset with a configuration, then move every setting afterwards.
    task automatic reset_link(input logic m64, input logic scr,
                              input logic fec, input logic [7:0] em1);
        rst <= 1'b1;
        realign <= 1'b1;
        in_valid <= 1'b0;
        sysref <= 1'b0;
        {cfg_mode64, cfg_scr, cfg_fec, cfg_e_m1} <= {m64, scr, fec, em1};
        cfg_f_m1 <= 8'h01;
        cfg_k_m1 <= 8'h03;
        // FEC parity fields are palindromes, so bit order is moot there; the CRC field 0xAB8 is not.
        shs_parity <= fec ? 26'h3FFFFF9 : 26'h0000AB8;
        repeat (5) tick();
        rst <= 1'b0;
        // Settings that move after release must be ignored.
        {cfg_mode64, cfg_scr, cfg_fec, cfg_e_m1} <= {~m64, ~scr, ~fec, ~em1};
        cfg_f_m1 <= 8'h07;
        cfg_k_m1 <= 8'h0F;
        tick();
    endtask

    // Pushes n octets; a full buffer must then refuse one more.
    task automatic fill(input int n);
        for (int i = 0; i < n; i++) begin
            chk(in_ready, 1);
            in_valid <= 1'b1;
            in_data <= din[i];
            tick();
        end
        if (n == 32) begin
            chk(in_ready, 0);
            in_data <= 8'hEE;
            tick();
        end
        in_valid <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    // 8B/10B bring-up, alignment sequence, marked data, then realign.
    task automatic run8(input logic scr);
        logic [7:0] pat [8];
        int i;
        int m;
        logic [7:0] e;
        logic k;
        pat = '{8'h01, 8'hFC, 8'h02, 8'h7C, 8'h03, 8'h7C, 8'h04, 8'h7C};
        for (i = 0; i < 32; i++) begin
            if (scr) begin
                din[i] = pat[i % 8];
                ek[i] = (i % 8 == 1) || (i % 8 == 7);
                eo[i] = din[i];
            end else begin
                din[i] = i[0] ? 8'h20 + 8'(i >> 2) : i[7:0];
                ek[i] = i[0] & i[1];
                eo[i] = ek[i] ? (i[2] ? K_A : K_F) : din[i];
            end
        end
        reset_link(1'b0, scr, 1'b0, 8'h00);
        fill(32);
        repeat (4) begin
            tick();
            chk({tx_k, tx_octet}, {1'b1, K_COMMA});
        end
        realign <= 1'b0;
        i = 0;
        while (!(tx_k === 1'b1 && tx_octet === K_R)) begin
            chk({tx_k, tx_octet}, {1'b1, K_COMMA});
            i++;
            if (i > 24) expire();
            tick();
        end
        for (i = 0; i < 32; i++) begin
            m = i % 8;
            k = (m == 0) || (m == 7);
            e = (m == 0) ? K_R : (m == 7) ? K_A : m[7:0];
            if (i / 8 == 1 && m == 1) {k, e} = {1'b1, K_Q};
            if (i / 8 == 1 && m == 2) e = 8'h01;
            if (i / 8 == 1 && m == 3) e = 8'h03;
            if (i / 8 == 1 && m == 4) e = {7'h00, scr};
            chk({tx_k, tx_octet}, {k, e});
            tick();
        end
        for (i = 0; i < 32; i++) begin
            chk({tx_k, tx_octet}, {ek[i], eo[i]});
            tick();
        end
        chk({underflow, tx_k, tx_octet}, {2'b10, IDLE_OCT});
        chk(scr_active, scr);
        // A sync request in mid-data falls back to commas.
        realign <= 1'b1;
        repeat (5) tick();
        chk({tx_k, tx_octet}, {1'b1, K_COMMA});
    endtask

    // 64B/66B blocks, headers and the header stream of E multiblocks.
    task automatic run64(input logic fec, input logic [7:0] em1,
                         input logic use_sr);
        int b;
        int n;
        logic [31:0] s;
        logic [31:0] x;
        logic [1:0] hd;
        for (b = 0; b < 8; b++) din[b] = 8'hA0 + b[7:0];
        reset_link(1'b1, 1'b0, fec, em1);
        fill(8);
        chk(scr_active, 1);
        if (use_sr) begin
            sysref <= 1'b1;
            tick();
            sysref <= 1'b0;
        end
        n = 0;
        while (tx_blk_valid !== 1'b1) begin
            n++;
            if (n > (use_sr ? 16 : 600)) expire();
            tick();
        end
        for (b = 0; b < 8; b++) chk(tx_blk[2 + 8 * b +: 8], din[b]);
        s = 32'h0;
        for (b = 0; b < 32 * (em1 + 1); b++) begin
            hd = tx_blk[1:0];
            chk(hd[0] ^ hd[1], 1);
            s[b % 32] = hd[1];
            if (b % 32 == 31) begin
                x = fec ? 32'h84BF_FFFF : 32'h80A8_8FAD;
                x[SH_EOEMB] = (b / 32 == em1);
                chk(s, x);
            end
            repeat (8) tick();
            chk(tx_blk_valid, 1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {rst, realign} = 2'b11;
        {cfg_mode64, cfg_scr, cfg_fec, sysref, in_valid} = 5'h00;
        {cfg_f_m1, cfg_k_m1, cfg_e_m1, in_data} = 32'h0103_0000;
        shs_parity = 26'h0;
        miscompares = 0;
        tests_run = 0;
        run8(1'b0);
        run8(1'b1);
        run64(1'b0, 8'h00, 1'b0);
        run64(1'b1, 8'h01, 1'b1);
        conclude();
    end
endmodule
